// ===== core/apmc_pkg.sv
// constants, encodings and register map of the actuator panel motor control block
package apmc_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ) / 1000;
  localparam int unsigned DEB_W = 17;

  // front-panel functions, one-hot
  localparam int unsigned FN_W = 7;
  typedef enum logic [6:0] {
    FN_AUTO     = 7'h01,
    FN_MAN_JOG  = 7'h02,
    FN_CLOSE    = 7'h04,
    FN_OPEN     = 7'h08,
    FN_CMD_TYPE = 7'h10,
    FN_CMD_LOST = 7'h20,
    FN_TRIP_SET = 7'h40
  } apmc_fn_t;

  // command types
  localparam logic [2:0] CMD_4_20MA = 3'h0;
  localparam logic [2:0] CMD_1_5V = 3'h1;
  localparam logic [2:0] CMD_0_5V = 3'h2;
  localparam logic [2:0] CMD_0_10V = 3'h3;
  localparam logic [2:0] CMD_2_10V = 3'h4;
  localparam logic [2:0] CMD_DIGITAL = 3'h5;
  localparam logic [2:0] CMD_LAST = 3'h5;

  // position upon command loss
  localparam logic [1:0] LOST_CLOSED = 2'h0;
  localparam logic [1:0] LOST_OPEN = 2'h1;
  localparam logic [1:0] LOST_HOLD = 2'h2;

  // position resolution and tracking
  localparam int unsigned POS_W = 9;
  localparam logic [8:0] POS_MAX = 9'h1c1;
  localparam logic [8:0] POS_MID = 9'h0e1;
  localparam logic [8:0] MID_TOL = 9'h004;
  localparam logic [8:0] DEADBAND = 9'h002;
  localparam logic [6:0] CMD_SCALE = 7'h49;
  localparam int unsigned CMD_SHIFT = 15;

  // motor current trip, units of 0.1 A
  localparam logic [7:0] TRIP_MAX = 8'h78;
  localparam logic [7:0] TRIP_RESET = 8'h64;

  // fault codes
  localparam logic [3:0] FAULT_NONE = 4'h0;
  localparam logic [3:0] FAULT_LOW_BAT = 4'h1;
  localparam logic [3:0] FAULT_TRIP = 4'h2;

  // indicator flashing
  localparam int unsigned BLINK_W = 24;
  localparam int unsigned BLINK_FAST_BIT = 19;

  // register map, byte addresses
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
  localparam logic [4:0] REG_TRIP = 5'h10;
  localparam logic [4:0] REG_FAULT = 5'h14;
  localparam logic [4:0] REG_POSITION = 5'h18;
  localparam logic [4:0] REG_FEEDBACK = 5'h1c;

  // field positions
  localparam int unsigned CTRL_TYPE_LSB = 0;
  localparam int unsigned CTRL_LOST_LSB = 3;
  localparam int unsigned POS_OPEN_LSB = 16;

  // interrupt events
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_FN_CHANGE = 0;
  localparam int unsigned IRQ_TRIP = 1;
  localparam int unsigned IRQ_OVERRIDE = 2;
  localparam int unsigned IRQ_LIMIT = 3;

  // reset values
  localparam logic [2:0] TYPE_RESET = CMD_4_20MA;
  localparam logic [1:0] LOST_RESET = LOST_HOLD;
  localparam logic [8:0] CLOSED_RESET = 9'h000;
  localparam logic [8:0] OPEN_RESET = 9'h1c1;

endpackage

// ===== core/apmc_motor_control.sv
// front-panel function sequencer and motor output control with avalon-mm registers
//
// Function
// R1 - up jogs A positive while limit A closed
// R2 - down jogs B positive while limit B closed
// R3 - motor off ties both outputs negative
// R4 - no limit switch closed means no drive
// R5 - mode press advances one function and indicator
// R6 - selected indicator steady, jog flashes, settings flash
// R7 - zero-based voltage types skip command-lost function
// R8 - override ignores mode, jog indicator steady
// R9 - normal operation only while override shorted
// R10 - motor polarity follows open and closed positions
// R11 - tracking mode adjusts continuously without calibration
// R12 - command type and loss position configurable
// R13 - fault indicator shows up to fifteen codes
// R14 - adjustable current trip limits motor drive
// R15 - stroke resolved into 450 positions
// R16 - adjust buttons act on selected function only
// R17 - buttons synchronised and debounced, one step
// R18 - reset starts braked in tracking mode
`timescale 1ns/10ps
module apmc_motor_control
  import apmc_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic btnMode,
  input wire logic btnUp,
  input wire logic btnDown,
  input wire logic overrideShorted,
  input wire logic travelLimitA,
  input wire logic travelLimitB,
  input wire logic [8:0] fbPos,
  input wire logic [8:0] cmdPos,
  input wire logic cmdLost,
  input wire logic [7:0] motorCurrent,
  input wire logic lowBattery,
  output logic motorAToPositive,
  output logic motorBToPositive,
  output logic [6:0] ledFn,
  output logic [3:0] faultCode,
  output logic irq,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [8:0] absDiff(input logic [8:0] a, input logic [8:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  function automatic logic [8:0] clampPos(input logic [8:0] p);
    return (p > POS_MAX) ? POS_MAX : p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [2:0] sync1_ff, sync2_ff, btnState_ff, btnPrev_ff;
  logic [2:0] nxt_sync1, nxt_sync2, nxt_btnState, nxt_btnPrev;
  logic [DEB_W-1:0] debCnt_ff [3];
  logic [DEB_W-1:0] nxt_debCnt [3];

  apmc_fn_t fn_ff, nxt_fn;
  logic override_ff, nxt_override;
  logic [2:0] cmdType_ff, nxt_cmdType;
  logic [1:0] lostPos_ff, nxt_lostPos;
  logic [8:0] closedPos_ff, nxt_closedPos;
  logic [8:0] openPos_ff, nxt_openPos;
  logic [7:0] tripLevel_ff, nxt_tripLevel;
  logic [3:0] swFault_ff, nxt_swFault;
  logic tripped_ff, nxt_tripped;
  logic [IRQ_W-1:0] irqStat_ff, nxt_irqStat;
  logic [IRQ_W-1:0] irqMask_ff, nxt_irqMask;
  logic [BLINK_W-1:0] blink_ff, nxt_blink;
  logic motorA_ff, nxt_motorA;
  logic motorB_ff, nxt_motorB;
  logic [6:0] led_ff, nxt_led;
  logic [3:0] fault_ff, nxt_fault;
  logic [8:0] target_ff, nxt_target;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;

  logic pressMode, pressUp, pressDown;
  logic busReq, busWr, reverse, wantA, wantB, driveBlocked;
  logic [31:0] status;
  logic [IRQ_W-1:0] events;
  logic signed [9:0] span;
  logic signed [26:0] scaled;

  ////////////////////////////////////////////////////////////////////////////////
  // button synchroniser and debounce

  always_comb begin
    logic [2:0] raw;
    raw = {btnDown, btnUp, btnMode};
    nxt_sync1 = raw;
    nxt_sync2 = sync1_ff;
    nxt_btnState = btnState_ff;
    nxt_btnPrev = btnState_ff;
    for (int i = 0; i < 3; i++) begin
      nxt_debCnt[i] = '0;
      if (sync2_ff[i] != btnState_ff[i]) begin // R17
        if (debCnt_ff[i] >= DEB_W'(DEB_CYCLES - 1)) begin
          nxt_btnState[i] = sync2_ff[i];
        end else begin
          nxt_debCnt[i] = debCnt_ff[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      btnState_ff <= '0;
      btnPrev_ff <= '0;
      for (int i = 0; i < 3; i++) begin
        debCnt_ff[i] <= '0;
      end
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      btnState_ff <= nxt_btnState;
      btnPrev_ff <= nxt_btnPrev;
      debCnt_ff <= nxt_debCnt;
    end
  end

  // one pulse per debounced press
  assign pressMode = btnState_ff[0] & ~btnPrev_ff[0]; // R17
  assign pressUp = btnState_ff[1] & ~btnPrev_ff[1];
  assign pressDown = btnState_ff[2] & ~btnPrev_ff[2];

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign busReq = avs_read | avs_write;
  assign busWr = avs_write & ack_ff;
  assign avs_waitrequest = busReq & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // larger open than closed setting means opening drives the position up
  assign reverse = closedPos_ff > openPos_ff; // R10

  assign status = {14'h0000, fault_ff, reverse, tripped_ff, travelLimitB, travelLimitA,
                   motorB_ff, motorA_ff, override_ff, fn_ff};

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer, settings, motor and registers

  assign span = $signed({1'b0, openPos_ff}) - $signed({1'b0, closedPos_ff});
  assign scaled = span * $signed({1'b0, cmdPos, 7'h00}) / $signed({1'b0, CMD_SCALE, 10'h000});

  always_comb begin
    logic [31:0] w;
    logic [8:0] err;
    nxt_fn = fn_ff;
    nxt_override = ~overrideShorted; // R9
    nxt_cmdType = cmdType_ff;
    nxt_lostPos = lostPos_ff;
    nxt_closedPos = closedPos_ff;
    nxt_openPos = openPos_ff;
    nxt_tripLevel = tripLevel_ff;
    nxt_swFault = swFault_ff;
    nxt_irqMask = irqMask_ff;
    nxt_blink = blink_ff + 1'b1;
    nxt_ack = busReq & ~ack_ff;
    nxt_rdata = rdata_ff;
    events = '0;
    wantA = 1'b0;
    wantB = 1'b0;
    w = '0;
    err = '0;

    // function stepping
    if (pressMode && !override_ff) begin // R8
      events[IRQ_FN_CHANGE] = 1'b1;
      case (fn_ff)
        FN_AUTO: nxt_fn = FN_MAN_JOG; // R5
        FN_MAN_JOG: nxt_fn = FN_CLOSE;
        FN_CLOSE: begin
          nxt_closedPos = clampPos(fbPos);
          nxt_fn = FN_OPEN;
        end
        FN_OPEN: begin
          nxt_openPos = clampPos(fbPos);
          nxt_fn = FN_CMD_TYPE;
        end
        FN_CMD_TYPE: begin
          if (cmdType_ff == CMD_0_5V || cmdType_ff == CMD_0_10V) begin // R7
            nxt_fn = FN_TRIP_SET;
          end else begin
            nxt_fn = FN_CMD_LOST;
          end
        end
        FN_CMD_LOST: nxt_fn = FN_TRIP_SET;
        FN_TRIP_SET: nxt_fn = FN_AUTO;
        default: nxt_fn = FN_AUTO;
      endcase
    end
    if (override_ff != nxt_override && nxt_override) begin
      events[IRQ_OVERRIDE] = 1'b1;
    end

    // adjust buttons only reach the selected function, never in tracking or override
    if (!override_ff) begin // R16
      case (fn_ff)
        FN_MAN_JOG, FN_CLOSE, FN_OPEN: begin
          wantA = btnState_ff[1] & ~btnState_ff[2]; // R1
          wantB = btnState_ff[2] & ~btnState_ff[1]; // R2
        end
        FN_CMD_TYPE: begin
          if (pressUp) begin // R12
            nxt_cmdType = (cmdType_ff == CMD_LAST) ? CMD_4_20MA : cmdType_ff + 3'h1;
          end else if (pressDown) begin
            nxt_cmdType = (cmdType_ff == CMD_4_20MA) ? CMD_LAST : cmdType_ff - 3'h1;
          end
        end
        FN_CMD_LOST: begin
          if (pressUp) begin // R12
            nxt_lostPos = (lostPos_ff == LOST_HOLD) ? LOST_CLOSED : lostPos_ff + 2'h1;
          end else if (pressDown) begin
            nxt_lostPos = (lostPos_ff == LOST_CLOSED) ? LOST_HOLD : lostPos_ff - 2'h1;
          end
        end
        FN_TRIP_SET: begin
          if (pressUp && tripLevel_ff < TRIP_MAX) begin // R14
            nxt_tripLevel = tripLevel_ff + 8'h01;
          end else if (pressDown && tripLevel_ff != 8'h00) begin
            nxt_tripLevel = tripLevel_ff - 8'h01;
          end
        end
        FN_AUTO: begin
          // target recomputed every cycle from the stored end positions, no calibration step
          nxt_target = target_ff; // R11
        end
        default: begin
        end
      endcase
    end

    // tracking target
    nxt_target = clampPos(9'(closedPos_ff + scaled[8:0])); // R15
    if (cmdLost && cmdType_ff != CMD_0_5V && cmdType_ff != CMD_0_10V) begin
      case (lostPos_ff)
        LOST_CLOSED: nxt_target = closedPos_ff;
        LOST_OPEN: nxt_target = openPos_ff;
        default: nxt_target = fbPos;
      endcase
    end
    if (fn_ff == FN_AUTO && !override_ff) begin
      err = absDiff(target_ff, fbPos);
      if (err > DEADBAND) begin // R11
        wantA = (target_ff > fbPos);
        wantB = (target_ff < fbPos);
      end
    end

    // current trip holds the motor off until the drive request goes away
    nxt_tripped = tripped_ff;
    if ((motorA_ff | motorB_ff) && motorCurrent > tripLevel_ff) begin // R14
      nxt_tripped = 1'b1;
      events[IRQ_TRIP] = ~tripped_ff;
    end else if (!wantA && !wantB) begin
      nxt_tripped = 1'b0;
    end
    driveBlocked = tripped_ff | override_ff;
    nxt_motorA = wantA & travelLimitA & ~driveBlocked; // R1 R4
    nxt_motorB = wantB & travelLimitB & ~driveBlocked; // R2 R4
    if ((wantA && !travelLimitA) || (wantB && !travelLimitB)) begin
      events[IRQ_LIMIT] = 1'b1;
    end

    // indicators
    nxt_led = fn_ff; // R6
    case (fn_ff)
      FN_MAN_JOG: begin
        err = absDiff(fbPos, POS_MID);
        if (err > MID_TOL) begin
          // farther from midrange picks a slower blink bit
          nxt_led[1] = blink_ff[BLINK_FAST_BIT + ((err[8:6] > 3'h4) ? 4 : err[8:6])]; // R6
        end
      end
      FN_CMD_TYPE: nxt_led[3'(cmdType_ff) % FN_W] = blink_ff[BLINK_FAST_BIT]; // R6
      FN_CMD_LOST: nxt_led[3'(lostPos_ff)] = blink_ff[BLINK_FAST_BIT];
      default: begin
      end
    endcase
    if (override_ff) begin
      nxt_led = FN_MAN_JOG; // R8
    end

    // fault indicator
    if (lowBattery) begin // R13
      nxt_fault = FAULT_LOW_BAT;
    end else if (tripped_ff) begin
      nxt_fault = FAULT_TRIP;
    end else begin
      nxt_fault = swFault_ff;
    end

    // register writes land on the edge where waitrequest is low
    if (busWr) begin
      case (avs_address)
        REG_CTRL: begin
          w = beMerge({27'h0, lostPos_ff, cmdType_ff}, avs_writedata, avs_byteenable);
          if (w[CTRL_TYPE_LSB +: 3] <= CMD_LAST) begin
            nxt_cmdType = w[CTRL_TYPE_LSB +: 3]; // R12
          end
          if (w[CTRL_LOST_LSB +: 2] <= LOST_HOLD) begin
            nxt_lostPos = w[CTRL_LOST_LSB +: 2];
          end
        end
        REG_IRQ_MASK: begin
          w = beMerge({28'h0, irqMask_ff}, avs_writedata, avs_byteenable);
          nxt_irqMask = w[IRQ_W-1:0];
        end
        REG_TRIP: begin
          w = beMerge({24'h0, tripLevel_ff}, avs_writedata, avs_byteenable);
          nxt_tripLevel = (w[7:0] > TRIP_MAX) ? TRIP_MAX : w[7:0]; // R14
        end
        REG_FAULT: begin
          w = beMerge({28'h0, swFault_ff}, avs_writedata, avs_byteenable);
          nxt_swFault = w[3:0]; // R13
        end
        REG_POSITION: begin
          w = beMerge({7'h00, openPos_ff, 7'h00, closedPos_ff}, avs_writedata, avs_byteenable);
          nxt_closedPos = clampPos(w[8:0]); // R15
          nxt_openPos = clampPos(w[POS_OPEN_LSB +: POS_W]);
        end
        default: begin
        end
      endcase
    end

    // sticky status, set wins over a one written to clear
    nxt_irqStat = irqStat_ff;
    if (busWr && avs_address == REG_IRQ_STAT && avs_byteenable[0]) begin
      nxt_irqStat = irqStat_ff & ~avs_writedata[IRQ_W-1:0];
    end
    nxt_irqStat = nxt_irqStat | events;

    // read data registered during the wait cycle
    if (avs_read && !ack_ff) begin
      case (avs_address)
        REG_CTRL: nxt_rdata = {27'h0, lostPos_ff, cmdType_ff};
        REG_STATUS: nxt_rdata = status;
        REG_IRQ_STAT: nxt_rdata = {28'h0, irqStat_ff};
        REG_IRQ_MASK: nxt_rdata = {28'h0, irqMask_ff};
        REG_TRIP: nxt_rdata = {24'h0, tripLevel_ff};
        REG_FAULT: nxt_rdata = {28'h0, swFault_ff};
        REG_POSITION: nxt_rdata = {7'h00, openPos_ff, 7'h00, closedPos_ff};
        REG_FEEDBACK: nxt_rdata = {7'h00, target_ff, 7'h00, fbPos};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fn_ff <= FN_AUTO; // R18
      motorA_ff <= 1'b0; // R18
      motorB_ff <= 1'b0;
      override_ff <= 1'b0;
      cmdType_ff <= TYPE_RESET;
      lostPos_ff <= LOST_RESET;
      closedPos_ff <= CLOSED_RESET;
      openPos_ff <= OPEN_RESET;
      tripLevel_ff <= TRIP_RESET;
      swFault_ff <= FAULT_NONE;
      tripped_ff <= 1'b0;
      irqStat_ff <= '0;
      irqMask_ff <= '0;
      blink_ff <= '0;
      led_ff <= FN_AUTO;
      fault_ff <= FAULT_NONE;
      target_ff <= CLOSED_RESET;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      fn_ff <= nxt_fn;
      motorA_ff <= nxt_motorA;
      motorB_ff <= nxt_motorB;
      override_ff <= nxt_override;
      cmdType_ff <= nxt_cmdType;
      lostPos_ff <= nxt_lostPos;
      closedPos_ff <= nxt_closedPos;
      openPos_ff <= nxt_openPos;
      tripLevel_ff <= nxt_tripLevel;
      swFault_ff <= nxt_swFault;
      tripped_ff <= nxt_tripped;
      irqStat_ff <= nxt_irqStat;
      irqMask_ff <= nxt_irqMask;
      blink_ff <= nxt_blink;
      led_ff <= nxt_led;
      fault_ff <= nxt_fault;
      target_ff <= nxt_target;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // low on both outputs shorts the motor leads to the negative supply
  assign motorAToPositive = motorA_ff; // R3
  assign motorBToPositive = motorB_ff; // R3
  assign ledFn = led_ff;
  assign faultCode = fault_ff;
  assign irq = |(irqStat_ff & irqMask_ff);

endmodule

// ===== tb/apmc_actuator_model.sv
// behavioural actuator: motor moves the feedback pot, limit switches open at the travel ends
`timescale 1ns/10ps
module apmc_actuator_model
  import apmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic motorAToPositive,
  input wire logic motorBToPositive,
  input wire logic limitsWired,
  output logic [8:0] fbPos,
  output logic travelLimitA,
  output logic travelLimitB
);
  logic [8:0] fbPos_ff;
  logic [8:0] nxt_fbPos;
  ////////////////////////////////////////////////////////////////////////////
  // one step per cycle; a braked or unpowered motor holds its position
  always_comb begin
    nxt_fbPos = fbPos_ff;
    if (motorAToPositive && !motorBToPositive && fbPos_ff != POS_MAX) begin
      nxt_fbPos = fbPos_ff + 9'h001;
    end else if (motorBToPositive && !motorAToPositive && fbPos_ff != 9'h000) begin
      nxt_fbPos = fbPos_ff - 9'h001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      fbPos_ff <= POS_MID;
    end else begin
      fbPos_ff <= nxt_fbPos;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // unwired switches read open, so neither direction is allowed
  assign fbPos = fbPos_ff;
  assign travelLimitA = limitsWired && (fbPos_ff != POS_MAX);
  assign travelLimitB = limitsWired && (fbPos_ff != 9'h000);
endmodule

// ===== tb/apmc_motor_control_assertions.sv
// concurrent checks on the ports of the panel motor control block
`timescale 1ns/10ps
module apmc_motor_control_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic overrideShorted,
  input wire logic travelLimitA,
  input wire logic travelLimitB,
  input wire logic motorAToPositive,
  input wire logic motorBToPositive,
  input wire logic [6:0] ledFn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_reset_state: assert property ($fell(rst) |-> !motorAToPositive && !motorBToPositive && ledFn == 7'h01)
    else $error("outputs not braked in tracking mode after reset");
  a_never_both: assert property (!(motorAToPositive && motorBToPositive))
    else $error("both motor outputs tied positive");
  a_up_limit: assert property ($rose(motorAToPositive) |-> $past(travelLimitA))
    else $error("output A driven with limit A open");
  a_down_limit: assert property ($rose(motorBToPositive) |-> $past(travelLimitB))
    else $error("output B driven with limit B open");
  a_no_limit_off: assert property ((!travelLimitA && !travelLimitB) [*2] |=> !motorAToPositive && !motorBToPositive)
    else $error("motor driven with no limit switch closed");
  a_ovr_led: assert property (!overrideShorted [*3] |-> ledFn == 7'h02)
    else $error("jog indicator not lit in override");
  a_ovr_brake: assert property (!overrideShorted [*3] |-> !motorAToPositive && !motorBToPositive)
    else $error("motor driven while override terminals open");
  a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait state");
  a_write_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait state");
  c_up: cover property ($rose(motorAToPositive));
  c_down: cover property ($rose(motorBToPositive));
  c_ovr: cover property ($fell(overrideShorted));
  c_nolim: cover property (!travelLimitA && !travelLimitB);
endmodule
bind apmc_motor_control apmc_motor_control_checker i_chk (
  .clk(clk), .rst(rst), .overrideShorted(overrideShorted),
  .travelLimitA(travelLimitA), .travelLimitB(travelLimitB),
  .motorAToPositive(motorAToPositive), .motorBToPositive(motorBToPositive), .ledFn(ledFn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest)
);

// ===== tb/tb_top.sv
// self-checking bench for the panel motor control block
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  import apmc_pkg::*;
  localparam int unsigned DEB = 4;
  localparam int unsigned PRESS = DEB + 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic btnMode = 1'b0;
  logic btnUp = 1'b0;
  logic btnDown = 1'b0;
  logic overrideShorted = 1'b1;
  logic limitsWired = 1'b1;
  logic lowBattery = 1'b0;
  logic [7:0] motorCurrent = 8'h00;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic travelLimitA;
  logic travelLimitB;
  logic [8:0] fbPos;
  logic motorAToPositive;
  logic motorBToPositive;
  logic [6:0] ledFn;
  logic [3:0] faultCode;
  logic irq;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  int err_count = 0;
  int checks = 0;
  apmc_fn_t fns [7] = '{FN_MAN_JOG, FN_CLOSE, FN_OPEN, FN_CMD_TYPE, FN_CMD_LOST, FN_TRIP_SET, FN_AUTO};
  logic [2:0] types [3] = '{CMD_4_20MA, CMD_0_5V, CMD_0_10V};

  always #50 clk = ~clk;

  apmc_motor_control #(.DEB_CYCLES(DEB)) i_dut (
    .clk(clk), .rst(rst), .btnMode(btnMode), .btnUp(btnUp), .btnDown(btnDown),
    .overrideShorted(overrideShorted), .travelLimitA(travelLimitA), .travelLimitB(travelLimitB),
    .fbPos(fbPos), .cmdPos(POS_MID), .cmdLost(1'b0), .motorCurrent(motorCurrent), .lowBattery(lowBattery),
    .motorAToPositive(motorAToPositive), .motorBToPositive(motorBToPositive), .ledFn(ledFn),
    .faultCode(faultCode), .irq(irq), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );
  apmc_actuator_model i_act (
    .clk(clk), .rst(rst), .motorAToPositive(motorAToPositive), .motorBToPositive(motorBToPositive),
    .limitsWired(limitsWired), .fbPos(fbPos), .travelLimitA(travelLimitA), .travelLimitB(travelLimitB)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches=%0d comparisons=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // waitrequest is looked at mid-cycle, which is the value the next rising edge samples; data is taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(negedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      err_count++;
      complete_run();
    end
  endtask

  // press and release both outlast the debounce
  task automatic press();
    @(posedge clk);
    btnMode <= 1'b1;
    repeat (PRESS) @(posedge clk);
    btnMode <= 1'b0;
    repeat (PRESS) @(posedge clk);
  endtask

  task automatic fn_is(input apmc_fn_t f);
    bus(1'b0, REG_STATUS, 32'h0, rd);
    `CHK(rd[6:0], f)
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    hold(0);
    `CHK({motorAToPositive, motorBToPositive}, 2'b00)
    `CHK(ledFn, 7'h01)
    fn_is(FN_AUTO);
    bus(1'b0, REG_TRIP, 32'h0, rd);
    `CHK(rd[7:0], TRIP_RESET)
    bus(1'b0, REG_CTRL, 32'h0, rd);
    `CHK(rd[4:0], {LOST_RESET, TYPE_RESET})
    bus(1'b0, 5'h1e, 32'h0, rd);
    `CHK(rd, 32'h0)
    lowBattery <= 1'b1;
    hold(3);
    `CHK(faultCode, FAULT_LOW_BAT)
    @(posedge clk);
    lowBattery <= 1'b0;
    // function change raises the interrupt while unmasked, and a one written to its status bit clears it
    bus(1'b1, REG_IRQ_STAT, 32'hf, rd);
    bus(1'b1, REG_IRQ_MASK, 32'h1, rd);
    press();
    fn_is(FN_MAN_JOG);
    `CHK(irq, 1'b1)
    bus(1'b1, REG_IRQ_STAT, 32'h1, rd);
    hold(0);
    `CHK(irq, 1'b0)
    bus(1'b1, REG_IRQ_MASK, 32'h0, rd);
    // jog up to the end of travel, where limit A opens
    btnUp <= 1'b1;
    hold(PRESS);
    `CHK({motorAToPositive, motorBToPositive}, 2'b10)
    @(posedge clk);
    limitsWired <= 1'b0;
    hold(3);
    `CHK({motorAToPositive, motorBToPositive}, 2'b00)
    @(posedge clk);
    limitsWired <= 1'b1;
    hold(300);
    `CHK(motorAToPositive, 1'b0)
    `CHK(fbPos, POS_MAX)
    @(posedge clk);
    btnUp <= 1'b0;
    btnDown <= 1'b1;
    hold(PRESS);
    `CHK({motorAToPositive, motorBToPositive}, 2'b01)
    @(posedge clk);
    motorCurrent <= 8'h70;
    hold(3);
    `CHK({motorAToPositive, motorBToPositive}, 2'b00)
    `CHK(faultCode, FAULT_TRIP)
    @(posedge clk);
    btnDown <= 1'b0;
    motorCurrent <= 8'h00;
    hold(PRESS);
    `CHK({motorAToPositive, motorBToPositive}, 2'b00)
    // full function ring for the 4-20 mA, 0-5 V and 0-10 V types; zero-based types drop the loss function
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, REG_CTRL, {27'h0, LOST_RESET, types[p]}, rd);
      for (int i = (p == 0) ? 1 : 0; i < 7; i++) begin
        if (!(fns[i] == FN_CMD_LOST && p > 0)) begin
          press();
          fn_is(fns[i]);
          hold(0);
          if (fns[i] != FN_MAN_JOG) begin
            `CHK(|(ledFn & fns[i]), 1'b1)
          end
        end
      end
    end
    @(posedge clk);
    overrideShorted <= 1'b0;
    hold(5);
    `CHK(ledFn[1], 1'b1)
    press();
    fn_is(FN_AUTO);
    `CHK(rd[7], 1'b1)
    bus(1'b0, REG_IRQ_STAT, 32'h0, rd);
    `CHK(rd[IRQ_OVERRIDE], 1'b1)
    overrideShorted <= 1'b1;
    hold(5);
    fn_is(FN_AUTO);
    bus(1'b1, REG_TRIP, 32'hc8, rd);
    bus(1'b0, REG_TRIP, 32'h0, rd);
    `CHK(rd[7:0], TRIP_MAX)
    bus(1'b1, REG_TRIP, 32'h32, rd);
    bus(1'b0, REG_TRIP, 32'h0, rd);
    `CHK(rd[7:0], 8'h32)
    complete_run();
  end
endmodule
